// ==== sfp_frame.sv ====
// Power-on state, SPI mode select and command framing of the serial flash interface.
// Function
// RULE_01: After power-on or any reset the interface defaults to SPI mode 3.
// RULE_02: After power-on or reset the serial output stays undriven until a command needs output.
// RULE_03: A new instruction starts only on a high-to-low transition of chip select.
// RULE_04: Each chip select falling edge samples the idle clock level, low giving mode 0 and high mode 3; edges during power-on reset are not sampled.
// RULE_05: The host waits at least 70 us after supply is valid before selecting the device.
// RULE_06: While the power-on reset is active all commands are ignored.
// RULE_07: After power-up the device sits in standby awaiting a chip select falling edge.
// RULE_08: Program or erase is blocked for the internal power-up delay of up to 5 ms.
// RULE_09: Opcode D2h carries two dummy bits, twelve page bits, ten byte bits and four dummy bytes.
// RULE_10: Opcodes D1h, D3h, D4h, D6h carry fourteen dummy bits and ten buffer bits; D4h and D6h add a dummy byte.
// RULE_11: All fields shift in MSB first on serial input, sampled on rising clock edges while selected.
`include "sfp_params.svh"
module sfp_frame #(
  parameter int PUW_CYCLES = `SFP_PUW_CYC
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         por_active_i,
  input  wire logic         sck_i,
  input  wire logic         cs_n_i,
  input  wire logic         si_i,
  input  wire logic         out_req_i,
  input  wire logic         out_bit_i,
  output logic              so_o,
  output logic              so_oe_o,
  output logic              mode3_o,
  output logic              standby_o,
  output logic              write_allowed_o,
  output sfp_pkg::sfp_cmd_type cmd_o,
  output logic              data_phase_o
);
  logic [2:0] pins_s;
  logic       sck_s, cs_n_s, si_s;
  logic       sck_p_q, cs_n_p_q;
  logic       cs_fall, sck_rise, sck_fall;
  logic [6:0] frame_rises_q;
  logic [5:0] bit_cnt_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [`SFP_CNT_W-1:0] puw_cnt_q;
  sfp_pkg::sfp_state_type state_q;

  sfp_sync #(.W(3), .RST_VAL(`SFP_PIN_IDLE)) u_sync (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i  ({sck_i, cs_n_i, si_i}),
    .sync_o   (pins_s)
  );
  assign {sck_s, cs_n_s, si_s} = pins_s;

  // Frame-matching on the sampled opcode keeps the decode in one place.
  function automatic logic is_buf_op(input logic [7:0] op);
    is_buf_op = (op == `SFP_OP_D1) || (op == `SFP_OP_D3) || (op == `SFP_OP_D4) || (op == `SFP_OP_D6);
  endfunction
  function automatic logic [5:0] dummy_bits(input logic [7:0] op);
    if (op == `SFP_OP_D2) dummy_bits = `SFP_D2_DUMMY_BITS;
    else if (op == `SFP_OP_D4 || op == `SFP_OP_D6) dummy_bits = `SFP_BUF_DUMMY_BITS;
    else dummy_bits = 6'h00;
  endfunction

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sck_p_q  <= 1'b1;
      cs_n_p_q <= 1'b1;
    end else begin
      sck_p_q  <= sck_s;
      cs_n_p_q <= cs_n_s;
    end
  end
  assign cs_fall  = cs_n_p_q & ~cs_n_s;
  assign sck_rise = ~sck_p_q & sck_s & ~cs_n_s;
  assign sck_fall = sck_p_q & ~sck_s & ~cs_n_s;

  // Mode register.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || por_active_i) begin
      mode3_o <= 1'b1; // RULE_01
    end else if (cs_fall) begin
      mode3_o <= sck_s; // RULE_04
    end
  end

  // Power-up write delay; counted from POR release, so it covers the worst case.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || por_active_i) begin
      puw_cnt_q       <= '0;
      write_allowed_o <= 1'b0;
    end else if (puw_cnt_q == PUW_CYCLES[`SFP_CNT_W-1:0]) begin
      write_allowed_o <= 1'b1; // RULE_08
    end else begin
      puw_cnt_q <= puw_cnt_q + 1'b1;
    end
  end

  // Framing state machine.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q   <= sfp_pkg::SFP_ST_POR;
      bit_cnt_q <= '0;
      op_q      <= '0;
      addr_q    <= '0;
    end else if (por_active_i) begin
      state_q <= sfp_pkg::SFP_ST_POR; // RULE_06
    end else if (cs_n_s) begin
      state_q <= sfp_pkg::SFP_ST_STANDBY; // RULE_07
    end else begin
      unique case (state_q)
        sfp_pkg::SFP_ST_POR: state_q <= sfp_pkg::SFP_ST_IGNORE;
        sfp_pkg::SFP_ST_STANDBY: begin
          if (cs_fall) begin // RULE_03
            state_q   <= sfp_pkg::SFP_ST_OPCODE;
            bit_cnt_q <= '0;
          end else begin
            state_q <= sfp_pkg::SFP_ST_IGNORE;
          end
        end
        sfp_pkg::SFP_ST_OPCODE: if (sck_rise) begin
          op_q      <= {op_q[6:0], si_s}; // RULE_11
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == `SFP_OP_BITS - 6'h01) begin
            bit_cnt_q <= '0;
            state_q   <= (is_buf_op({op_q[6:0], si_s}) || {op_q[6:0], si_s} == `SFP_OP_D2) ?
                         sfp_pkg::SFP_ST_ADDR : sfp_pkg::SFP_ST_IGNORE;
          end
        end
        sfp_pkg::SFP_ST_ADDR: if (sck_rise) begin
          addr_q    <= {addr_q[22:0], si_s}; // RULE_11
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == `SFP_ADDR_BITS - 6'h01) begin
            bit_cnt_q <= '0;
            state_q   <= (dummy_bits(op_q) == 6'h00) ? sfp_pkg::SFP_ST_DATA : sfp_pkg::SFP_ST_DUMMY; // RULE_09 RULE_10
          end
        end
        sfp_pkg::SFP_ST_DUMMY: if (sck_rise) begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == dummy_bits(op_q) - 6'h01) begin // RULE_09 RULE_10
            bit_cnt_q <= '0;
            state_q   <= sfp_pkg::SFP_ST_DATA;
          end
        end
        sfp_pkg::SFP_ST_DATA: state_q <= sfp_pkg::SFP_ST_DATA;
        sfp_pkg::SFP_ST_IGNORE: state_q <= sfp_pkg::SFP_ST_IGNORE;
        default: state_q <= sfp_pkg::SFP_ST_IGNORE;
      endcase
    end
  end

  // Decoded command, presented when the frame reaches its data phase.
  // Clearing on power-on reset too keeps a frame cut by reset from showing a data phase.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || por_active_i || cs_n_s) begin
      cmd_o        <= '0;
      data_phase_o <= 1'b0;
      standby_o    <= cs_n_s & ~sys_rst_i & ~por_active_i; // RULE_07
    end else begin
      standby_o    <= 1'b0;
      data_phase_o <= (state_q == sfp_pkg::SFP_ST_DATA);
      cmd_o.valid  <= (state_q == sfp_pkg::SFP_ST_DATA);
      cmd_o.opcode <= op_q;
      cmd_o.page   <= is_buf_op(op_q) ? 12'h000 : addr_q[`SFP_PAGE_MSB:`SFP_PAGE_LSB]; // RULE_09
      cmd_o.byte_addr <= addr_q[`SFP_BYTE_MSB:0]; // RULE_10
    end
  end

  // Output pin: launched on falling clock edges, enabled only in a data phase that wants output.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || por_active_i || cs_n_s) begin
      so_oe_o <= 1'b0; // RULE_02
      so_o    <= 1'b0;
    end else begin
      so_oe_o <= (state_q == sfp_pkg::SFP_ST_DATA) && out_req_i; // RULE_02
      if (sck_fall) begin
        so_o <= out_bit_i;
      end
    end
  end

  // Sampled clock rises in the current frame, saturating, so that frame lengths can be checked.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || cs_n_s) begin
      frame_rises_q <= '0;
    end else if (sck_rise && frame_rises_q != 7'h7F) begin
      frame_rises_q <= frame_rises_q + 7'h01;
    end
  end

  property p_por_quiet;
    @(posedge mclk_i) disable iff (sys_rst_i)
      por_active_i |=> !so_oe_o && !data_phase_o && mode3_o;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("Activity during power-on reset."); // RULE_06

  property p_mode_sample;
    @(posedge mclk_i) disable iff (sys_rst_i || por_active_i)
      cs_fall |=> (mode3_o == $past(sck_s));
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("Mode not taken from idle clock."); // RULE_04

  property p_rst_mode3;
    @(posedge mclk_i) $fell(sys_rst_i) |-> mode3_o;
  endproperty
  a_rst_mode3: assert property (p_rst_mode3) else $error("Mode 3 not default after reset."); // RULE_01

  property p_oe_only_data;
    @(posedge mclk_i) disable iff (sys_rst_i)
      so_oe_o |-> $past(state_q == sfp_pkg::SFP_ST_DATA && !cs_n_s && out_req_i);
  endproperty
  a_oe_only_data: assert property (p_oe_only_data) else $error("Output driven outside data phase."); // RULE_02

  property p_start_on_fall;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (state_q == sfp_pkg::SFP_ST_STANDBY) ##1 (state_q == sfp_pkg::SFP_ST_OPCODE) |-> $past(cs_fall);
  endproperty
  a_start_on_fall: assert property (p_start_on_fall) else $error("Frame began without select fall."); // RULE_03

  property p_puw_block;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(write_allowed_o) |-> puw_cnt_q == PUW_CYCLES[`SFP_CNT_W-1:0];
  endproperty
  a_puw_block: assert property (p_puw_block) else $error("Write allowed early."); // RULE_08

  property p_standby;
    @(posedge mclk_i) disable iff (sys_rst_i || por_active_i)
      cs_n_s ##1 cs_n_s |=> standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("Not in standby while deselected."); // RULE_07

  property p_d2_len;
    @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(data_phase_o) && cmd_o.opcode == `SFP_OP_D2 |->
        frame_rises_q == 7'(`SFP_OP_BITS) + 7'(`SFP_ADDR_BITS) + 7'(`SFP_D2_DUMMY_BITS);
  endproperty
  a_d2_len: assert property (p_d2_len) else $error("D2h frame decoded wrongly."); // RULE_09
endmodule // sfp_frame

// ==== sfp_frame_bench.sv ====
// Self-checking bench for the power-up and command framing block.
module sfp_frame_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 mclk, rst, por, sck, cs_n, si, oreq, obit;
  logic                 so, so_oe, mode3, stby, wr_ok, dph;
  sfp_pkg::sfp_cmd_type cmd;
  int                   n_fail, compares;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // A short write delay keeps the run brief.
  sfp_frame #(.PUW_CYCLES(50)) dut_u (.mclk_i(mclk), .sys_rst_i(rst), .por_active_i(por), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .out_req_i(oreq), .out_bit_i(obit), .so_o(so), .so_oe_o(so_oe),
    .mode3_o(mode3), .standby_o(stby), .write_allowed_o(wr_ok), .cmd_o(cmd), .data_phase_o(dph));

  sfp_host_model host_u (.mclk_i(mclk), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic t_reset;
    chk(32'(mode3), 32'h1);
    chk(32'(so_oe), 32'h0);
    chk(32'(stby), 32'h1);
    chk(32'(wr_ok), 32'h0);
  endtask

  task automatic t_d2;
    host_u.start(1'b0);
    chk(32'(mode3), 32'h0);
    chk(32'(stby), 32'h0);
    host_u.bits(32'hD2, 8);
    host_u.bits({8'h00, 2'b11, 12'hA5C, 10'h2B7}, 24);
    host_u.bits(32'h5A5A5A5A, 31);
    chk(32'(dph), 32'h0);
    host_u.bits(32'h0, 1);
    repeat (4) @(negedge mclk);
    chk(32'(dph), 32'h1);
    chk(32'(cmd.valid), 32'h1);
    chk(32'(cmd.opcode), 32'hD2);
    chk(32'(cmd.page), 32'hA5C);
    chk(32'(cmd.byte_addr), 32'h2B7);
    oreq = 1'b1;
    obit = 1'b1;
    host_u.bits(32'h0, 1);
    chk(32'(so_oe), 32'h1);
    chk(32'(so), 32'h1);
    obit = 1'b0;
    host_u.bits(32'h0, 1);
    chk(32'(so), 32'h0);
    host_u.stop(1'b0);
    oreq = 1'b0;
    chk(32'(dph), 32'h0);
    chk(32'(so_oe), 32'h0);
    chk(32'(stby), 32'h1);
  endtask

  task automatic t_buf;
    logic [7:0] ops [4];
    int         nd  [4];
    logic       md;
    ops = '{8'hD1, 8'hD3, 8'hD4, 8'hD6};
    nd  = '{0, 0, 8, 8};
    for (int i = 0; i < 4; i++) begin
      md = i[0];
      host_u.start(md);
      chk(32'(mode3), 32'(md));
      host_u.bits(32'(ops[i]), 8);
      host_u.bits({8'h00, 14'h2AAA, 10'h3C5}, 24);
      repeat (4) @(negedge mclk);
      chk(32'(dph), 32'(nd[i] == 0));
      if (nd[i] != 0) begin
        host_u.bits(32'h5A, 8);
        repeat (4) @(negedge mclk);
        chk(32'(dph), 32'h1);
      end
      chk(32'(cmd.opcode), 32'(ops[i]));
      chk(32'(cmd.byte_addr), 32'h3C5);
      chk(32'(cmd.page), 32'h0);
      host_u.stop(md);
    end
  endtask

  // A valid frame hidden behind a refused opcode must not start without a new select.
  task automatic t_refuse;
    logic [7:0] op;
    logic       md;
    for (int k = 0; k < 2; k++) begin
      md = k[0];
      op = md ? 8'hD7 : 8'h9F;
      host_u.start(md);
      host_u.bits(32'(op), 8);
      host_u.bits(32'hD2A5C2B7, 32);
      host_u.bits(32'h0, 32);
      repeat (4) @(negedge mclk);
      chk(32'(dph), 32'h0);
      chk(32'(cmd.valid), 32'h0);
      host_u.stop(md);
    end
  endtask

  task automatic t_por;
    por = 1'b1;
    host_u.start(1'b0);
    chk(32'(mode3), 32'h1);
    host_u.bits(32'hD1, 8);
    host_u.bits(32'h0, 24);
    repeat (4) @(negedge mclk);
    chk(32'(dph), 32'h0);
    chk(32'(stby), 32'h0);
    por = 1'b0;
    repeat (40) @(negedge mclk);
    chk(32'(wr_ok), 32'h0);
    repeat (20) @(negedge mclk);
    chk(32'(wr_ok), 32'h1);
    // Select stayed low across the reset release, so this frame has no falling edge to start it.
    host_u.bits(32'hD1, 8);
    host_u.bits(32'h0, 24);
    repeat (4) @(negedge mclk);
    chk(32'(dph), 32'h0);
    host_u.stop(1'b0);
    chk(32'(stby), 32'h1);
  endtask

  initial begin
    rst  = 1'b1;
    por  = 1'b0;
    oreq = 1'b0;
    obit = 1'b0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    repeat (1400) @(negedge mclk);
    t_d2();
    t_buf();
    t_refuse();
    t_por();
    complete_run();
  end

  // The tests take about 0.25 ms, so 2 ms means the run has hung.
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
endmodule // sfp_frame_bench

// ==== sfp_host_model.sv ====
// Behavioural SPI host that frames commands for the serial flash interface.
module sfp_host_model (
  input  wire logic mclk_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sck_o  = 1'b1;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // The idle clock level is set before select falls, which picks the mode.
  task automatic start(input logic idle);
    @(negedge mclk_i);
    sck_o = idle;
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask

  // Each bit is set while the clock is low and sampled on the rise, MSB first.
  task automatic bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o  = v[i];
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge mclk_i);
    end
  endtask

  // A released data line must not keep its last value, so it is inverted.
  task automatic stop(input logic idle);
    sck_o = idle;
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    repeat (4) @(negedge mclk_i);
  endtask
endmodule // sfp_host_model

// ==== sfp_params.svh ====
// Constants for the serial flash power-up and command framing block.
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH
`define SFP_CLK_NS          50
`define SFP_PUW_MS          5
`define SFP_PUW_CYC         ((`SFP_PUW_MS * 1000000 + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_CNT_W           17
`define SFP_PIN_IDLE        3'h6
`define SFP_OP_D1           8'hD1
`define SFP_OP_D2           8'hD2
`define SFP_OP_D3           8'hD3
`define SFP_OP_D4           8'hD4
`define SFP_OP_D6           8'hD6
`define SFP_OP_BITS         6'h08
`define SFP_ADDR_BITS       6'h18
`define SFP_D2_DUMMY_BITS   6'h20
`define SFP_BUF_DUMMY_BITS  6'h08
`define SFP_PAGE_LSB        10
`define SFP_PAGE_MSB        21
`define SFP_BYTE_MSB        9
`endif

// ==== sfp_pkg.sv ====
// Types for the serial flash power-up and command framing block.
package sfp_pkg;
  typedef enum logic [2:0] {
    SFP_ST_POR     = 3'h0,
    SFP_ST_STANDBY = 3'h1,
    SFP_ST_OPCODE  = 3'h2,
    SFP_ST_ADDR    = 3'h3,
    SFP_ST_DUMMY   = 3'h4,
    SFP_ST_DATA    = 3'h5,
    SFP_ST_IGNORE  = 3'h6
  } sfp_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [11:0] page;
    logic [9:0] byte_addr;
  } sfp_cmd_type;
endpackage

// ==== sfp_sync.sv ====
// Two-flop synchroniser bank for the serial pins.
module sfp_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      // Resetting to the pins' idle levels keeps a false edge from following reset.
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // sfp_sync
